// file: core/sld_regs.svh
// Register map, field positions and reset values of the segment LCD control block
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH

`define SLD_ADDR_W 16
`define SLD_OFS_DISP_CTRL 16'h50a0
`define SLD_OFS_FRAME_DUTY 16'h50a2
`define SLD_OFS_REGULATOR 16'h50a3
`define SLD_OFS_IRQ_MASK 16'h50a5
`define SLD_OFS_IRQ_STATUS 16'h50a6

`define SLD_POS_INVERT 4
`define SLD_POS_DISP_STATE 0
`define SLD_POS_FRAME_DIV 6
`define SLD_POS_DUTY 0
`define SLD_POS_HEAVY_LOAD 4
`define SLD_POS_REF_SEL 0
`define SLD_POS_FRAME_IRQ 0

`define SLD_RST_INVERT 1'h1
`define SLD_RST_DISP_STATE 2'h0
`define SLD_RST_FRAME_DIV 2'h1
`define SLD_RST_DUTY 3'h3
`define SLD_RST_HEAVY_LOAD 1'h0
`define SLD_RST_REF_SEL 1'h0
`define SLD_RST_IRQ_EN 1'h0

`define SLD_DSP_OFF 2'h0
`define SLD_DSP_NORMAL 2'h1
`define SLD_DSP_ALL_ON 2'h2
`define SLD_DSP_ALL_OFF 2'h3

`define SLD_DUTY_STATIC 3'h0
`define SLD_DUTY_HALF 3'h1
`define SLD_DUTY_THIRD 3'h2

`define SLD_NUM_SEG 32
`define SLD_NUM_COM 4

`endif

// file: core/sld_pkg.sv
// Types shared by the segment LCD control block
package sld_pkg;

  typedef struct packed {
    logic [1:0] display_state_sel;
    logic invert_display_n;
    logic [1:0] frame_divider_sel;
    logic [2:0] drive_duty_sel;
  } sld_ctrl_t;

  typedef struct packed {
    logic [1:0] com_idx;
    logic frame;
  } sld_timing_t;

endpackage

// file: core/sld_frame_timer.sv
// Frame divider and common scan counter driven by the LCD clock tick
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_frame_timer
  import sld_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Control
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic [1:0] frame_divider_sel_in,
  input wire logic [2:0] drive_duty_sel_in,
  // Timing
  output sld_timing_t timing_out
);

  typedef struct packed {
    logic [3:0] pos;
    logic [4:0] slot;
    logic [1:0] com;
    logic frame;
  } sld_ft_state_t;

  sld_ft_state_t state_ff;
  sld_ft_state_t nxt_state;
  logic [4:0] frame_len;
  logic [2:0] num_com;
  logic [4:0] slot_len;

  always_comb begin
    // Frame length in LCD clock ticks
    if (drive_duty_sel_in == `SLD_DUTY_THIRD) begin
      frame_len = 5'(({3'h0, frame_divider_sel_in} + 5'h2) * 5'h3);
    end else begin
      frame_len = 5'(({3'h0, frame_divider_sel_in} + 5'h1) * 5'h4);
    end
    // Active commons per duty; reserved codes behave as 1/4
    case (drive_duty_sel_in)
      `SLD_DUTY_STATIC: num_com = 3'h1;
      `SLD_DUTY_HALF: num_com = 3'h2;
      `SLD_DUTY_THIRD: num_com = 3'h3;
      default: num_com = 3'h4;
    endcase
    slot_len = frame_len / {2'h0, num_com};
    nxt_state = state_ff;
    if (!run_in) begin
      nxt_state.pos = 4'h0;
      nxt_state.slot = 5'h0;
      nxt_state.com = 2'h0;
      nxt_state.frame = 1'h0;
    end else if (tick_in) begin
      if ({1'h0, state_ff.pos} >= frame_len - 5'h1) begin
        nxt_state.pos = 4'h0;
        nxt_state.slot = 5'h0;
        nxt_state.com = 2'h0;
      end else begin
        nxt_state.pos = state_ff.pos + 4'h1;
        if (state_ff.slot >= slot_len - 5'h1) begin
          nxt_state.slot = 5'h0;
          nxt_state.com = state_ff.com + 2'h1;
        end else begin
          nxt_state.slot = state_ff.slot + 5'h1;
        end
      end
      // High in the first half of each frame, so it rises once per frame
      nxt_state.frame = ({1'h0, nxt_state.pos} < (frame_len >> 1));
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign timing_out = {state_ff.com, state_ff.frame};

endmodule

// file: core/sld_seg_mux.sv
// Per-segment drive selection for the common line being scanned
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_seg_mux
  import sld_pkg::*;
(
  // Control
  input wire logic [1:0] display_state_sel_in,
  input wire logic invert_display_n_in,
  input wire logic [1:0] com_idx_in,
  // Display memory, common-major
  input wire logic [4*`SLD_NUM_SEG-1:0] dmem_in,
  // Drive
  output logic [`SLD_NUM_SEG-1:0] seg_out
);

  logic invert;

  // Inversion acts on the waveform only, the memory is never rewritten
  assign invert = ~invert_display_n_in;

  // All 32 segments stay live at every duty
  for (genvar i = 0; i < `SLD_NUM_SEG; i++) begin : g_seg
    logic mem_bit;
    assign mem_bit = dmem_in[{com_idx_in, 5'(i)}];
    always_comb begin
      case (display_state_sel_in)
        `SLD_DSP_NORMAL: seg_out[i] = mem_bit ^ invert;
        `SLD_DSP_ALL_ON: seg_out[i] = ~invert;
        `SLD_DSP_ALL_OFF: seg_out[i] = 1'h0;
        default: seg_out[i] = 1'h0;
      endcase
    end
  end

endmodule

// file: core/sld_top.sv
// Segment LCD display control: registers, sleep handling, frame interrupt, drive outputs
// How it works
// - Inversion bit 0 inverts the panel, 1 is normal; memory untouched.
// - Display field: 0 off, 1 normal, 2 all on dynamic, 3 all off static.
// - Display off stops drive voltage and grounds the three reference outputs.
// - All on/off override the waveform only; commons dynamic for on, static off.
// - Display field reads 0 after reset.
// - Sleep forces the display field to 0; wake restores the value held at entry or written while asleep.
// - Frame divider codes 0..3 give 1/4, 1/8, 1/12, 1/16; reset 1.
// - At 1/3 duty the divider codes give 1/6, 1/9, 1/12, 1/15.
// - Frame rate is the prescaled clock divided by the duty-dependent divisor.
// - Duty field: static, 1/2, 1/3, 1/4 commons; reserved above; reset 3.
// - All 32 segments active at every duty.
// - Regulator register: heavy-load protect bit 4, reference select bit 0, reset 0.
// - Mask bit 0 enables the frame interrupt; reset 0.
// - Frame flag sets on frame rising edge; write one clears, zero ignored.
// - Interrupt request while frame flag and enable are both one.
// - Inversion skipped for all off, applied for all on.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_top
  import sld_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // Register port
  input wire logic [`SLD_ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // System
  input wire logic SLEEP_IN,
  input wire logic LCD_TICK_IN,
  input wire logic [4*`SLD_NUM_SEG-1:0] DMEM_IN,
  // Panel drive
  output logic [`SLD_NUM_COM-1:0] COM_OUT,
  output logic [`SLD_NUM_SEG-1:0] SEG_OUT,
  output logic FRAME_OUT,
  // Power circuit
  output logic VC_DRIVE_EN_OUT,
  output logic [2:0] VC_GROUND_OUT,
  output logic HEAVY_LOAD_PROTECT_OUT,
  output logic REF_SEL_OUT,
  // Interrupt
  output logic IRQ_OUT
);

  typedef struct packed {
    sld_ctrl_t ctrl;
    logic [1:0] saved_state;
    logic sleep_d;
    logic heavy_load_protect_en;
    logic reference_voltage_sel;
    logic frame_irq_enable;
    logic frame_irq_flag;
    logic frame_d;
    logic [7:0] rdata;
    logic [`SLD_NUM_COM-1:0] com;
    logic [`SLD_NUM_SEG-1:0] seg;
    logic frame;
    logic vc_en;
    logic [2:0] vc_gnd;
    logic irq;
  } sld_top_state_t;

  sld_top_state_t state_ff;
  sld_top_state_t nxt_state;
  sld_timing_t timing;
  logic [`SLD_NUM_SEG-1:0] seg_drive;
  logic run;
  logic wr_disp_ctrl;
  logic wr_frame_duty;
  logic wr_regulator;
  logic wr_irq_mask;
  logic wr_irq_status;
  logic frame_rise;
  logic [2:0] num_com;
  logic [`SLD_NUM_COM-1:0] com_mask;
  logic [7:0] rd_value;

  // The scan runs only while something is shown; display off parks the counters
  assign run = (state_ff.ctrl.display_state_sel != `SLD_DSP_OFF);

  sld_frame_timer u_frame_timer (
    .clk_in(CLOCK_IN),
    .srst_in(SRST_IN),
    .tick_in(LCD_TICK_IN),
    .run_in(run),
    .frame_divider_sel_in(state_ff.ctrl.frame_divider_sel),
    .drive_duty_sel_in(state_ff.ctrl.drive_duty_sel),
    .timing_out(timing)
  );

  sld_seg_mux u_seg_mux (
    .display_state_sel_in(state_ff.ctrl.display_state_sel),
    .invert_display_n_in(state_ff.ctrl.invert_display_n),
    .com_idx_in(timing.com_idx),
    .dmem_in(DMEM_IN),
    .seg_out(seg_drive)
  );

  assign wr_disp_ctrl = WR_IN && (ADDR_IN == `SLD_OFS_DISP_CTRL);
  assign wr_frame_duty = WR_IN && (ADDR_IN == `SLD_OFS_FRAME_DUTY);
  assign wr_regulator = WR_IN && (ADDR_IN == `SLD_OFS_REGULATOR);
  assign wr_irq_mask = WR_IN && (ADDR_IN == `SLD_OFS_IRQ_MASK);
  assign wr_irq_status = WR_IN && (ADDR_IN == `SLD_OFS_IRQ_STATUS);
  assign frame_rise = timing.frame && !state_ff.frame_d;

  // Valid commons for the current duty
  always_comb begin
    case (state_ff.ctrl.drive_duty_sel)
      `SLD_DUTY_STATIC: num_com = 3'h1;
      `SLD_DUTY_HALF: num_com = 3'h2;
      `SLD_DUTY_THIRD: num_com = 3'h3;
      default: num_com = 3'h4;
    endcase
    com_mask = 4'(({1'h0, 4'h1} << num_com) - 5'h1);
  end

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rd_value = 8'h00;
    case (ADDR_IN)
      `SLD_OFS_DISP_CTRL: begin
        rd_value[`SLD_POS_INVERT] = state_ff.ctrl.invert_display_n;
        rd_value[`SLD_POS_DISP_STATE +: 2] = state_ff.ctrl.display_state_sel;
      end
      `SLD_OFS_FRAME_DUTY: begin
        rd_value[`SLD_POS_FRAME_DIV +: 2] = state_ff.ctrl.frame_divider_sel;
        rd_value[`SLD_POS_DUTY +: 3] = state_ff.ctrl.drive_duty_sel;
      end
      `SLD_OFS_REGULATOR: begin
        rd_value[`SLD_POS_HEAVY_LOAD] = state_ff.heavy_load_protect_en;
        rd_value[`SLD_POS_REF_SEL] = state_ff.reference_voltage_sel;
      end
      `SLD_OFS_IRQ_MASK: begin
        rd_value[`SLD_POS_FRAME_IRQ] = state_ff.frame_irq_enable;
      end
      `SLD_OFS_IRQ_STATUS: begin
        rd_value[`SLD_POS_FRAME_IRQ] = state_ff.frame_irq_flag;
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.sleep_d = SLEEP_IN;
    nxt_state.frame_d = timing.frame;
    nxt_state.rdata = RD_IN ? rd_value : 8'h00;

    // Register writes; only defined fields are stored
    if (wr_disp_ctrl) begin
      nxt_state.ctrl.invert_display_n = WDATA_IN[`SLD_POS_INVERT];
      if (SLEEP_IN) begin
        // Asleep: the write lands in the value restored on wake
        nxt_state.saved_state = WDATA_IN[`SLD_POS_DISP_STATE +: 2];
      end else begin
        nxt_state.ctrl.display_state_sel = WDATA_IN[`SLD_POS_DISP_STATE +: 2];
      end
    end
    if (wr_frame_duty) begin
      nxt_state.ctrl.frame_divider_sel = WDATA_IN[`SLD_POS_FRAME_DIV +: 2];
      nxt_state.ctrl.drive_duty_sel = WDATA_IN[`SLD_POS_DUTY +: 3];
    end
    if (wr_regulator) begin
      nxt_state.heavy_load_protect_en = WDATA_IN[`SLD_POS_HEAVY_LOAD];
      nxt_state.reference_voltage_sel = WDATA_IN[`SLD_POS_REF_SEL];
    end
    if (wr_irq_mask) begin
      nxt_state.frame_irq_enable = WDATA_IN[`SLD_POS_FRAME_IRQ];
    end

    // Sleep entry parks the display field at off, wake puts it back
    if (SLEEP_IN && !state_ff.sleep_d) begin
      nxt_state.saved_state = wr_disp_ctrl ? WDATA_IN[`SLD_POS_DISP_STATE +: 2]
                                      : state_ff.ctrl.display_state_sel;
      nxt_state.ctrl.display_state_sel = `SLD_DSP_OFF;
    end else if (!SLEEP_IN && state_ff.sleep_d) begin
      nxt_state.ctrl.display_state_sel = state_ff.saved_state;
    end

    // Write-one-to-clear; a frame edge in the same cycle wins
    if (wr_irq_status && WDATA_IN[`SLD_POS_FRAME_IRQ]) begin
      nxt_state.frame_irq_flag = 1'h0;
    end
    if (frame_rise) begin
      nxt_state.frame_irq_flag = 1'h1;
    end
    nxt_state.irq = nxt_state.frame_irq_flag && nxt_state.frame_irq_enable;

    // Common drive per display state
    case (state_ff.ctrl.display_state_sel)
      `SLD_DSP_NORMAL, `SLD_DSP_ALL_ON: begin
        nxt_state.com = 4'(4'h1 << timing.com_idx) & com_mask;
      end
      `SLD_DSP_ALL_OFF: begin
        nxt_state.com = 4'h1;
      end
      default: begin
        nxt_state.com = 4'h0;
      end
    endcase
    nxt_state.seg = seg_drive;
    nxt_state.frame = timing.frame;

    // Display off removes the drive voltage and grounds the references
    nxt_state.vc_en = run;
    nxt_state.vc_gnd = run ? 3'h0 : 3'h7;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      state_ff <= '0;
      state_ff.ctrl.display_state_sel <= `SLD_RST_DISP_STATE;
      state_ff.ctrl.invert_display_n <= `SLD_RST_INVERT;
      state_ff.ctrl.frame_divider_sel <= `SLD_RST_FRAME_DIV;
      state_ff.ctrl.drive_duty_sel <= `SLD_RST_DUTY;
      state_ff.heavy_load_protect_en <= `SLD_RST_HEAVY_LOAD;
      state_ff.reference_voltage_sel <= `SLD_RST_REF_SEL;
      state_ff.frame_irq_enable <= `SLD_RST_IRQ_EN;
      state_ff.vc_gnd <= 3'h7;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign RDATA_OUT = state_ff.rdata;
  assign COM_OUT = state_ff.com;
  assign SEG_OUT = state_ff.seg;
  assign FRAME_OUT = state_ff.frame;
  assign VC_DRIVE_EN_OUT = state_ff.vc_en;
  assign VC_GROUND_OUT = state_ff.vc_gnd;
  assign HEAVY_LOAD_PROTECT_OUT = state_ff.heavy_load_protect_en;
  assign REF_SEL_OUT = state_ff.reference_voltage_sel;
  assign IRQ_OUT = state_ff.irq;

endmodule

// file: dv/sld_props.sv
// Port-level assertions for the segment LCD control block
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_props
  import sld_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  // Register port and system
  input wire logic [`SLD_ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic SLEEP_IN,
  // Outputs watched
  input wire logic [`SLD_NUM_COM-1:0] COM_OUT,
  input wire logic [`SLD_NUM_SEG-1:0] SEG_OUT,
  input wire logic VC_DRIVE_EN_OUT,
  input wire logic [2:0] VC_GROUND_OUT,
  input wire logic IRQ_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);

  property p_rd_idle;
    !$past(RD_IN) |-> RDATA_OUT == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped;
    $past(RD_IN) && $past(ADDR_IN) == 16'h50a1 |-> RDATA_OUT == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask_rsv;
    $past(RD_IN) && $past(ADDR_IN) == `SLD_OFS_IRQ_MASK |-> RDATA_OUT[7:1] == 7'h00;
  endproperty
  a_mask_rsv: assert property (p_mask_rsv) else $error("mask reserved bits set");
  property p_off_write;
    WR_IN && ADDR_IN == `SLD_OFS_DISP_CTRL && WDATA_IN[1:0] == `SLD_DSP_OFF |-> ##3 !VC_DRIVE_EN_OUT;
  endproperty
  a_off_write: assert property (p_off_write) else $error("drive on after display off");
  property p_sleep_off;
    $rose(SLEEP_IN) |-> ##3 !VC_DRIVE_EN_OUT && VC_GROUND_OUT == 3'h7;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep left drive on");
  property p_ground;
    VC_GROUND_OUT == {3{!VC_DRIVE_EN_OUT}};
  endproperty
  a_ground: assert property (p_ground) else $error("reference grounding wrong");
  property p_com_onehot;
    COM_OUT != 4'h0 |-> $onehot(COM_OUT);
  endproperty
  a_com_onehot: assert property (p_com_onehot) else $error("two commons selected");
  property p_all_off;
    WR_IN && ADDR_IN == `SLD_OFS_DISP_CTRL && WDATA_IN[1:0] == `SLD_DSP_ALL_OFF && !SLEEP_IN
      ##1 (!WR_IN && !SLEEP_IN) [*3] |-> COM_OUT == 4'h1 && SEG_OUT == '0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("all off not static blank");
  property p_irq_off;
    WR_IN && ADDR_IN == `SLD_OFS_IRQ_MASK && !WDATA_IN[0] |-> ##2 !IRQ_OUT;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked irq still high");
endmodule

bind sld_top sld_props u_props (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .SLEEP_IN(SLEEP_IN),
  .COM_OUT(COM_OUT), .SEG_OUT(SEG_OUT), .VC_DRIVE_EN_OUT(VC_DRIVE_EN_OUT),
  .VC_GROUND_OUT(VC_GROUND_OUT), .IRQ_OUT(IRQ_OUT));

// file: dv/sld_panel_model.sv
// Passive panel: keeps the segment pattern last driven under each common
`timescale 1ns/1ps
`include "sld_regs.svh"

module sld_panel_model
  import sld_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Drive lines
  input wire logic [`SLD_NUM_COM-1:0] com_in,
  input wire logic [`SLD_NUM_SEG-1:0] seg_in,
  // Image seen
  output logic [4*`SLD_NUM_SEG-1:0] image_out
);
  always_ff @(posedge clk_in) begin
    for (int c = 0; c < `SLD_NUM_COM; c++) begin
      if (com_in[c]) begin
        image_out[c*`SLD_NUM_SEG +: `SLD_NUM_SEG] <= seg_in;
      end
    end
  end
endmodule

// file: dv/sld_tb.sv
// Self-checking bench for the segment LCD control block
`timescale 1ns/1ps
`include "sld_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic tick = 1'b0;
  logic [127:0] dmem = 128'h0123456789abcdef_fedcba9876543210;
  logic [7:0] rdata;
  logic [3:0] com;
  logic [31:0] seg;
  logic [2:0] gnd;
  logic [127:0] image;
  logic frame, vc_en, heavy, refs, irq;
  int n_mismatch = 0;
  int num_checks = 0;

  sld_top u_dut (.CLOCK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .SLEEP_IN(sleep), .LCD_TICK_IN(tick), .DMEM_IN(dmem),
    .COM_OUT(com), .SEG_OUT(seg), .FRAME_OUT(frame), .VC_DRIVE_EN_OUT(vc_en), .VC_GROUND_OUT(gnd),
    .HEAVY_LOAD_PROTECT_OUT(heavy), .REF_SEL_OUT(refs), .IRQ_OUT(irq));
  sld_panel_model u_panel (.clk_in(clk), .com_in(com), .seg_in(seg), .image_out(image));

  task end_sim;
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data lives only in the cycle after the strobe
  task rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  // Outputs lag the counters, so allow two edges after each tick
  // Ticks stand for the supplied LCD clock, given whenever a display state is shown
  task tk(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    #1;
  endtask

  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task t_reset;
    `CHK("vc_en", 1'b0, vc_en)
    `CHK("gnd", 3'h7, gnd)
    rdc(`SLD_OFS_DISP_CTRL, 8'h10);
    rdc(`SLD_OFS_FRAME_DUTY, 8'h43);
    rdc(`SLD_OFS_REGULATOR, 8'h00);
    rdc(`SLD_OFS_IRQ_MASK, 8'h00);
    rdc(16'h50a1, 8'h00);
  endtask

  task t_rsv;
    wrr(`SLD_OFS_REGULATOR, 8'hff);
    wrr(16'h50a1, 8'hff);
    rdc(`SLD_OFS_REGULATOR, 8'h11);
    `CHK("heavy", 1'b1, heavy)
    `CHK("ref", 1'b1, refs)
    wrr(`SLD_OFS_IRQ_MASK, 8'hfe);
    rdc(`SLD_OFS_IRQ_MASK, 8'h00);
    wrr(`SLD_OFS_FRAME_DUTY, 8'hff);
    rdc(`SLD_OFS_FRAME_DUTY, 8'hc7);
    wrr(`SLD_OFS_DISP_CTRL, 8'hfc);
    rdc(`SLD_OFS_DISP_CTRL, 8'h10);
    wrr(`SLD_OFS_REGULATOR, 8'h00);
  endtask

  task t_drive;
    logic [7:0] dv [5] = '{8'h11, 8'h01, 8'h12, 8'h02, 8'h03};
    logic [31:0] e;
    wrr(`SLD_OFS_FRAME_DUTY, 8'h40);
    foreach (dv[i]) begin
      wrr(`SLD_OFS_DISP_CTRL, dv[i]);
      tk(1);
      e = (dv[i][1:0] == 2'h1) ? dmem[31:0] ^ {32{~dv[i][4]}} : (dv[i][1:0] == 2'h2) ? {32{dv[i][4]}} : 32'h0;
      `CHK("seg", e, seg)
      `CHK("com", 4'h1, com)
    end
    wrr(`SLD_OFS_FRAME_DUTY, 8'h43);
    // Off parks the scan at common 0, so eight ticks then visit every common
    wrr(`SLD_OFS_DISP_CTRL, 8'h10);
    wrr(`SLD_OFS_DISP_CTRL, 8'h11);
    tk(8);
    `CHK("image", dmem, image)
    wrr(`SLD_OFS_DISP_CTRL, 8'h12);
    tk(8);
    `CHK("image", {128{1'b1}}, image)
  endtask

  task t_frame;
    int last, n;
    logic [3:0] acc;
    logic fp;
    for (int d = 0; d < 4; d++) begin
      for (int f = 0; f < 4; f++) begin
        wrr(`SLD_OFS_FRAME_DUTY, {f[1:0], 3'h0, d[2:0]});
        last = -1;
        n = 0;
        acc = 4'h0;
        fp = frame;
        for (int t = 0; t < 40; t++) begin
          tk(1);
          if (frame && !fp) begin
            n = t - last;
            last = t;
          end
          fp = frame;
          if (t > 20) acc |= com;
        end
        `CHK("frame_len", (d == 2) ? 6 + 3 * f : 4 + 4 * f, n)
        `CHK("coms", 4'((1 << (d + 1)) - 1), acc)
      end
    end
  endtask

  task t_sleep;
    wrr(`SLD_OFS_DISP_CTRL, 8'h11);
    @(posedge clk);
    sleep <= 1'b1;
    settle;
    `CHK("vc_en", 1'b0, vc_en)
    rdc(`SLD_OFS_DISP_CTRL, 8'h10);
    wrr(`SLD_OFS_DISP_CTRL, 8'h12);
    rdc(`SLD_OFS_DISP_CTRL, 8'h10);
    @(posedge clk);
    sleep <= 1'b0;
    settle;
    rdc(`SLD_OFS_DISP_CTRL, 8'h12);
    `CHK("vc_en", 1'b1, vc_en)
  endtask

  task t_irq;
    wrr(`SLD_OFS_IRQ_STATUS, 8'h01);
    wrr(`SLD_OFS_IRQ_MASK, 8'h01);
    rdc(`SLD_OFS_IRQ_STATUS, 8'h00);
    `CHK("irq", 1'b0, irq)
    tk(17);
    `CHK("irq", 1'b1, irq)
    rdc(`SLD_OFS_IRQ_STATUS, 8'h01);
    wrr(`SLD_OFS_IRQ_MASK, 8'h00);
    settle;
    `CHK("irq", 1'b0, irq)
    wrr(`SLD_OFS_IRQ_MASK, 8'h01);
    wrr(`SLD_OFS_IRQ_STATUS, 8'h00);
    settle;
    `CHK("irq", 1'b1, irq)
    wrr(`SLD_OFS_IRQ_STATUS, 8'h01);
    settle;
    `CHK("irq", 1'b0, irq)
  endtask

  initial begin
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset;
    t_rsv;
    t_drive;
    t_frame;
    t_sleep;
    t_irq;
    end_sim;
  end

  // Whole run needs about 2800 cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
endmodule
